/* File: hw/sfio_host_port.sv */
// Purpose: host command port of a smart serial channel controller
// Assumes: link engine on clk answers each request with a done pulse
// Notes:   register access over AXI4-Lite, one write and one read at a time
//
// Summary of operation
// [R01] elements fill words LSB first, word0 to word2
// [R02] element order follows the index table order
// [R03] inputs read back, outputs written by host
// [R04] host loads outgoing words before transfer cycle
// [R05] cycle end: incoming bytes and status in registers
// [R06] 0x800 stops all, command clears when done
// [R07] 0x9NN normal start, clear marks completion
// [R08] start failures flagged per channel in data
// [R09] unit number readable until first cycle
// [R10] host writes command only when clear
// [R11] failed cycle channels flagged in data register
// [R12] 0x10NN starts a cycle on masked channels
// [R13] cycle command clears within 100 us
// [R14] all channels idle after reset and stop
// [R15] 0xFNN setup start enters pass-through mode
// [R16] host reads via 0x45 word in status register
// [R17] word read result lands in low word0
// [R18] byte to double reads differ only in size
// [R19] mode record: 0xB0, index, type, unused, name
// [R20] mode type 0x00 hardware, 0x01 software
// [R21] name string follows unit string terminator
// [R22] default mode outputs in word0 and word1 bytes
// [R23] low status byte holds sticky faults, stop clears
// [R24] word write: data word0, 0x65 command word
// [R25] unmasked channels keep their state and words
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "sfio_consts.svh"

module sfio_host_port #(
   parameter logic [7:0] HW_MODE_INDEX = 8'h00,
   parameter logic [7:0] SW_MODE_INDEX = 8'h00
) (
   input  logic                    clk,
   input  logic                    sys_rst,
   input  sfio_pkg::sfio_axil_req_s axiReq,
   output sfio_pkg::sfio_axil_rsp_s axiRsp,
   output sfio_pkg::sfio_link_req_s linkReq,
   input  sfio_pkg::sfio_link_rsp_s linkRsp
);
   import sfio_pkg::*;

   localparam logic [11:0] CycLast = 12'(`SFIO_CYCLE_CYC - 1);

   sfio_state_s st;
   sfio_state_s next_st;
   logic        wrGo;
   logic        cmdWr;
   logic        chWr;
   logic [31:0] cmdFull;
   logic [15:0] cmdVal;
   logic        timeoutNow;
   logic [63:0] fltAll;

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ========================================================================
   // decoded write events, shared by the register writes and the checks
   assign wrGo   = st.haveAw & st.haveW & ~st.axi.bvalid;
   assign cmdWr  = wrGo & (st.awAddr == `SFIO_OFF_CMD);
   assign chWr   = wrGo & (st.awAddr[11:7] == `SFIO_CH_REGION);
   assign cmdFull = mergeBytes({16'h0000, st.cmd}, st.wData, st.wStrb);
   assign cmdVal  = cmdFull[15:0];
   // a long cycle is cut short so the host always sees the clear in time
   assign timeoutNow = (st.op == OP_CYCLE) & (st.fsm != FSM_IDLE)
                     & (st.timer == CycLast);                          // [R13]

   // ========================================================================
   // next-state logic
   always_comb begin
      logic        adv;
      logic [2:0]  ch;
      logic [1:0]  wi;
      logic [31:0] rd;
      logic        hit;
      sfio_op_e    newOp;
      adv   = 1'b0;
      ch    = 3'h0;
      wi    = 2'h0;
      rd    = 32'h0000_0000;
      hit   = 1'b0;
      newOp = OP_NONE;
      next_st = st;
      next_st.link.stop = 1'b0;
      if (st.fsm != FSM_IDLE) begin
         next_st.timer = st.timer + 12'h001;
      end
      // address and data channels are taken independently
      if (axiReq.awvalid & st.axi.awready) begin
         next_st.haveAw = 1'b1;
         next_st.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid & st.axi.wready) begin
         next_st.haveW = 1'b1;
         next_st.wData = axiReq.wdata;
         next_st.wStrb = axiReq.wstrb;
      end
      if (st.axi.bvalid & axiReq.bready) begin
         next_st.axi.bvalid = 1'b0;
      end
      // ---- sequencer ----
      unique case (st.fsm)
         FSM_IDLE: begin
         end
         FSM_ISSUE: begin
            if (st.op == OP_STOP) begin
               next_st.cmd = 16'h0000;                                // [R06]
               next_st.fsm = FSM_IDLE;
            end else if (!st.mask[st.chan]) begin
               adv = 1'b1;                                            // [R25]
            end else if ((st.op == OP_CYCLE) &&
                         (st.mode[st.chan] == CHM_IDLE)) begin
               next_st.data[st.chan] = 1'b1;                          // [R11]
               adv = 1'b1;
            end else begin
               // outgoing words go out verbatim, byte 0 first
               next_st.link.req   = 1'b1;                       // [R04] [R12]
               next_st.link.op    = st.op;
               next_st.link.chan  = st.chan;
               next_st.link.setup = (st.mode[st.chan] == CHM_SETUP);
               next_st.link.ptCmd = st.pt[st.chan];             // [R16] [R24]
               next_st.link.outw  = st.ifw[st.chan];      // [R01] [R02] [R22]
               next_st.fsm        = FSM_WAIT;
            end
         end
         FSM_WAIT: begin
            if (linkRsp.done) begin
               next_st.link.req = 1'b0;
               adv = 1'b1;
               if (linkRsp.fail) begin
                  next_st.data[st.chan] = 1'b1;                 // [R08] [R11]
                  if (st.op != OP_CYCLE) begin
                     next_st.mode[st.chan] = CHM_IDLE;
                  end
               end else begin
                  // start leaves unit number, name and pointers here;
                  // the first cycle without a link failure overwrites them with incoming data
                  next_st.ifw[st.chan] =
                     linkRsp.inw;                  // [R05] [R09] [R17] [R21]
                  next_st.cs[st.chan][31:8] = linkRsp.status;         // [R05]
                  if (st.op == OP_NSTART) begin
                     next_st.mode[st.chan] = CHM_NORMAL;              // [R07]
                  end else if (st.op == OP_SSTART) begin
                     next_st.mode[st.chan] = CHM_SETUP;               // [R15]
                  end
               end
            end
         end
         default: begin
            next_st.fsm = FSM_IDLE;
         end
      endcase
      if (adv) begin
         if (st.chan == 3'h7) begin
            next_st.cmd = 16'h0000;                                   // [R07]
            next_st.fsm = FSM_IDLE;
         end else begin
            next_st.chan = st.chan + 3'h1;
            next_st.fsm  = FSM_ISSUE;
         end
      end
      if (timeoutNow) begin
         for (int i = 0; i < 8; i++) begin
            if (st.mask[i] && (3'(i) >= st.chan) &&
                !((3'(i) == st.chan) && adv)) begin
               next_st.data[i] = 1'b1;                                // [R13]
            end
         end
         next_st.cmd      = 16'h0000;                                 // [R13]
         next_st.fsm      = FSM_IDLE;
         next_st.link.req = 1'b0;
      end
      // ---- register writes ----
      if (wrGo) begin
         next_st.haveAw     = 1'b0;
         next_st.haveW      = 1'b0;
         next_st.axi.bvalid = 1'b1;
         next_st.axi.bresp  = `SFIO_RESP_OK;
         ch = st.awAddr[6:4];
         wi = st.awAddr[3:2];
         if (cmdWr) begin
            if (cmdVal[`SFIO_CMD_IGNORE]) begin
               newOp = OP_NONE;
            end else if (cmdVal == `SFIO_CMD_STOP) begin
               newOp = OP_STOP;                                       // [R06]
            end else if (st.cmd != 16'h0000) begin
               newOp = OP_NONE;                                       // [R10]
            end else begin
               unique case (cmdVal[15:8])
                  `SFIO_CODE_NSTART: newOp = OP_NSTART;               // [R07]
                  `SFIO_CODE_SSTART: newOp = OP_SSTART;               // [R15]
                  `SFIO_CODE_CYCLE:  newOp = OP_CYCLE;                // [R12]
                  default:           newOp = OP_NONE;
               endcase
            end
            if (newOp != OP_NONE) begin
               next_st.cmd      = cmdVal;
               next_st.op       = newOp;
               next_st.mask     = cmdVal[7:0];
               next_st.data     = 8'h00;
               next_st.chan     = 3'h0;
               next_st.timer    = 12'h000;
               next_st.fsm      = FSM_ISSUE;
               next_st.link.req = 1'b0;
            end
            if (newOp == OP_STOP) begin
               next_st.link.stop = 1'b1;
               for (int i = 0; i < 8; i++) begin
                  next_st.mode[i]     = CHM_IDLE;                     // [R14]
                  next_st.cs[i][7:0]  = 8'h00;                        // [R23]
               end
            end
         end else if (st.awAddr[11:7] == `SFIO_CH_REGION) begin
            if (wi == 2'h0) begin
               // host command word for pass-through, status reads back
               next_st.pt[ch] = mergeBytes(st.pt[ch], st.wData, st.wStrb);
            end else begin
               next_st.ifw[ch][wi - 2'h1] =
                  mergeBytes(st.ifw[ch][wi - 2'h1], st.wData, st.wStrb);
            end
         end else if ((st.awAddr != `SFIO_OFF_DATA) &&
                      (st.awAddr != `SFIO_OFF_HWDESC) &&
                      (st.awAddr != `SFIO_OFF_SWDESC)) begin
            next_st.axi.bresp = `SFIO_RESP_ERR;
         end
      end
      // faults set after the stop clear, so an event in that cycle stays
      for (int i = 0; i < 8; i++) begin
         next_st.cs[i][7:0] = next_st.cs[i][7:0] | linkRsp.flt[i];    // [R23]
      end
      // ---- register reads ----
      if (st.axi.rvalid & axiReq.rready) begin
         next_st.axi.rvalid = 1'b0;
      end
      if (axiReq.arvalid & st.axi.arready) begin
         hit = 1'b1;
         ch  = axiReq.araddr[6:4];
         wi  = axiReq.araddr[3:2];
         if (axiReq.araddr == `SFIO_OFF_CMD) begin
            rd = {16'h0000, st.cmd};
         end else if (axiReq.araddr == `SFIO_OFF_DATA) begin
            rd = {24'h000000, st.data};                         // [R08] [R11]
         end else if (axiReq.araddr == `SFIO_OFF_HWDESC) begin
            // record: type, index, mode type, unused; name from byte 4
            rd = {8'h00, `SFIO_MODE_HW, HW_MODE_INDEX,
                  `SFIO_MODE_REC};                              // [R19] [R20]
         end else if (axiReq.araddr == `SFIO_OFF_SWDESC) begin
            rd = {8'h00, `SFIO_MODE_SW, SW_MODE_INDEX,
                  `SFIO_MODE_REC};                              // [R19] [R20]
         end else if (axiReq.araddr[11:7] == `SFIO_CH_REGION) begin
            if (wi == 2'h0) begin
               rd = st.cs[ch];                                        // [R05]
            end else begin
               rd = st.ifw[ch][wi - 2'h1];                      // [R03] [R18]
            end
         end else begin
            hit = 1'b0;
         end
         next_st.axi.rvalid = 1'b1;
         next_st.axi.rdata  = rd;
         next_st.axi.rresp  = hit ? `SFIO_RESP_OK : `SFIO_RESP_ERR;
      end
      // ready only while the slot is free, so nothing can be dropped
      next_st.axi.awready = ~next_st.haveAw & ~next_st.axi.bvalid;
      next_st.axi.wready  = ~next_st.haveW & ~next_st.axi.bvalid;
      next_st.axi.arready = ~next_st.axi.rvalid;
   end

   // ========================================================================
   // state register; all channels idle out of reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st      <= '0;                                               // [R14]
         st.fsm  <= FSM_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign axiRsp  = st.axi;
   assign linkReq = st.link;

   // ========================================================================
   // checks
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flt
         assign fltAll[gi*8 +: 8] = st.cs[gi][7:0];
      end
   endgenerate

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   AST_STOP_IDLES: assert property (                            // [R06] [R14]
      cmdWr && !cmdVal[`SFIO_CMD_IGNORE] && (cmdVal == `SFIO_CMD_STOP)
      |=> (st.mode == '0) && (st.cmd == `SFIO_CMD_STOP)
          ##1 (st.cmd == 16'h0000))
      else $error("stop did not idle channels and clear command");

   AST_BUSY_IGNORE: assert property (                                 // [R10]
      cmdWr && !cmdVal[`SFIO_CMD_IGNORE] && (st.cmd != 16'h0000) &&
      (cmdVal != `SFIO_CMD_STOP)
      |=> (st.cmd == $past(st.cmd)) || (st.cmd == 16'h0000))
      else $error("busy command register was overwritten");

   AST_CYCLE_BOUND: assert property (                                 // [R13]
      (st.op == OP_CYCLE) && (st.cmd != 16'h0000)
      |-> (st.timer <= CycLast))
      else $error("transfer cycle command did not clear in time");

   AST_LOAD_IN: assert property (                               // [R05] [R17]
      (st.fsm == FSM_WAIT) && linkRsp.done && !linkRsp.fail && !timeoutNow
      && !chWr
      |=> st.ifw[$past(st.chan)] == $past(linkRsp.inw))
      else $error("incoming words not loaded at completion");

   AST_FAIL_IDLE: assert property (                                   // [R11]
      (st.fsm == FSM_ISSUE) && (st.op == OP_CYCLE) && st.mask[st.chan] &&
      (st.mode[st.chan] == CHM_IDLE) && !cmdWr
      |=> st.data[$past(st.chan)])
      else $error("cycle on an idle channel not flagged");

   AST_START_FAIL: assert property (                                  // [R08]
      (st.fsm == FSM_WAIT) && (st.op != OP_CYCLE) && linkRsp.done &&
      linkRsp.fail && !cmdWr
      |=> st.data[$past(st.chan)] && (st.mode[$past(st.chan)] == CHM_IDLE))
      else $error("failed start not flagged");

   AST_STICKY: assert property (                                      // [R23]
      !(cmdWr && (cmdVal == `SFIO_CMD_STOP))
      |=> ($past(fltAll) & ~fltAll) == 64'h0)
      else $error("sticky fault flag fell without stop");

   AST_UNSEL_KEEP: assert property (                                  // [R25]
      (st.fsm != FSM_IDLE) && !st.mask[0] && !chWr && !cmdWr
      |=> $stable(st.ifw[0]) && $stable(st.mode[0]))
      else $error("unselected channel changed");

   AST_REQ_HOLD: assert property (                                    // [R12]
      st.link.req && !linkRsp.done && !timeoutNow && !cmdWr
      |=> st.link.req && $stable(st.link.chan))
      else $error("link request dropped early");

   AST_BVALID_HOLD: assert property (
      st.axi.bvalid && !axiReq.bready
      |=> st.axi.bvalid && $stable(st.axi.bresp))
      else $error("write response withdrawn");

   COV_STOP: cover property (st.link.stop ##1 (st.cmd == 16'h0000));
   COV_START: cover property (
      (st.fsm == FSM_WAIT) && (st.op == OP_NSTART) && linkRsp.done);
   COV_CYCLE: cover property (
      (st.op == OP_CYCLE) && (st.fsm == FSM_WAIT) && linkRsp.done &&
      (st.chan == 3'h7));
   COV_TIMEOUT: cover property (timeoutNow);
   COV_SETUP: cover property (
      st.link.req && st.link.setup && linkRsp.done);
endmodule

/* File: shared/sfio_consts.svh */
// Purpose: constants of the serial field I/O host command port
// Assumes: 40 MHz clk, eight serial channels
// Notes:   byte addresses on the AXI4-Lite register bus
`ifndef SFIO_CONSTS_SVH
`define SFIO_CONSTS_SVH
// ==========================================================================
// register map
`define SFIO_OFF_CMD       12'h000
`define SFIO_OFF_DATA      12'h004
`define SFIO_OFF_HWDESC    12'h008
`define SFIO_OFF_SWDESC    12'h00c
`define SFIO_CH_REGION     5'h02
`define SFIO_RESP_OK       2'b00
`define SFIO_RESP_ERR      2'b10
// ==========================================================================
// command codes, high byte, low byte is the channel mask
`define SFIO_CMD_STOP      16'h0800
`define SFIO_CODE_NSTART   8'h09
`define SFIO_CODE_SSTART   8'h0f
`define SFIO_CODE_CYCLE    8'h10
`define SFIO_CMD_IGNORE    15
// ==========================================================================
// mode descriptor record
`define SFIO_MODE_REC      8'hb0
`define SFIO_MODE_HW       8'h00
`define SFIO_MODE_SW       8'h01
`define SFIO_MODE_NAME_AT  8'h04
// ==========================================================================
// timing
`define SFIO_CLK_NS        25
`define SFIO_CYCLE_TIME_NS 100000
`define SFIO_CYCLE_CYC     (`SFIO_CYCLE_TIME_NS / `SFIO_CLK_NS)
`endif

/* File: shared/sfio_pkg.sv */
// Purpose: types of the serial field I/O host command port
// Assumes: eight channels, three interface words each
// Notes:   one-hot sequencer codes
package sfio_pkg;
   // =======================================================================
   // enumerations
   typedef enum logic [2:0] {
      FSM_IDLE  = 3'b001,
      FSM_ISSUE = 3'b010,
      FSM_WAIT  = 3'b100
   } sfio_fsm_e;
   typedef enum logic [2:0] {
      OP_NONE   = 3'h0,
      OP_STOP   = 3'h1,
      OP_NSTART = 3'h2,
      OP_SSTART = 3'h3,
      OP_CYCLE  = 3'h4
   } sfio_op_e;
   typedef enum logic [1:0] {
      CHM_IDLE   = 2'h0,
      CHM_NORMAL = 2'h1,
      CHM_SETUP  = 2'h2
   } sfio_chmode_e;
   // =======================================================================
   // bus and link carriers
   typedef struct packed {
      logic [11:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [11:0] araddr;
      logic        arvalid;
      logic        rready;
   } sfio_axil_req_s;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } sfio_axil_rsp_s;
   typedef struct packed {
      logic            req;
      logic            stop;
      sfio_op_e        op;
      logic [2:0]      chan;
      logic            setup;
      logic [31:0]     ptCmd;
      logic [2:0][31:0] outw;
   } sfio_link_req_s;
   typedef struct packed {
      logic             done;
      logic             fail;
      logic [23:0]      status;
      logic [2:0][31:0] inw;
      logic [7:0][7:0]  flt;
   } sfio_link_rsp_s;
   // =======================================================================
   // whole state of the port
   typedef struct packed {
      sfio_fsm_e             fsm;
      sfio_op_e              op;
      logic [2:0]            chan;
      logic [7:0]            mask;
      logic [11:0]           timer;
      logic [15:0]           cmd;
      logic [7:0]            data;
      sfio_chmode_e [7:0]    mode;
      logic [7:0][31:0]      cs;
      logic [7:0][31:0]      pt;
      logic [7:0][2:0][31:0] ifw;
      logic                  haveAw;
      logic                  haveW;
      logic [11:0]           awAddr;
      logic [31:0]           wData;
      logic [3:0]            wStrb;
      sfio_axil_rsp_s        axi;
      sfio_link_req_s        link;
   } sfio_state_s;
endpackage

/* File: testbench/sfio_link_model.sv */
// Purpose: behavioural link engine with remote devices
// Assumes: one request at a time, done ends it
// Notes:   answer words are a fixed function of the request
`timescale 1ns/1ps
module sfio_link_model
   import sfio_pkg::*;
(
   input  logic           clk,
   input  logic           sys_rst,
   input  sfio_link_req_s linkReq,
   input  logic [7:0]     failMask,
   input  logic [7:0]     fltBits,
   input  logic [7:0]     delay,
   output sfio_link_rsp_s linkRsp
);
   logic [7:0]       cnt;
   logic             done;
   logic [31:0]      d;
   logic [2:0][31:0] w;
   // =====================================================================
   // answer after a set delay, one done pulse per request
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt  <= 8'h00;
         done <= 1'b0;
      end else begin
         done <= linkReq.req && !done && cnt >= delay;
         cnt  <= (linkReq.req && !done && !linkReq.stop) ? cnt + 8'h01
                                                         : 8'h00;
      end
   end
   // words are inverted off the done cycle, so stale data never matches
   always_comb begin
      d = {linkReq.ptCmd[15:0], linkReq.ptCmd[15:0] ^ 16'h5a5a};
      w = ~linkReq.outw ^ {3{29'h0, linkReq.chan}};
      if (linkReq.op != OP_CYCLE) begin
         w = {64'h0, 32'h1000 | 32'(linkReq.chan)};
      end else if (linkReq.setup) begin
         case (linkReq.ptCmd[31:24])
            8'h44: w[0] = d & 32'hff;
            8'h45: w[0] = d & 32'hffff;
            8'h46: w[0] = d;
            default: w[1:0] = {~d, d};
         endcase
      end
      linkRsp.done   = done;
      linkRsp.fail   = done & failMask[linkReq.chan];
      linkRsp.status = {5'h0, linkReq.chan, 16'h0300};
      linkRsp.inw    = done ? w : ~w;
      linkRsp.flt    = '0;
      linkRsp.flt[linkReq.chan] = done ? fltBits : 8'h00;
   end
endmodule

/* File: testbench/testbench.sv */
// Purpose: self-checking bench of the host command port
// Assumes: link model answers after delay cycles
// Notes:   expected words follow the model's answer rules
`timescale 1ns/1ps
module testbench;
   import sfio_pkg::*;
   logic           clk = 1'b0;
   logic           sys_rst = 1'b1;
   sfio_axil_req_s req = '0;
   sfio_axil_rsp_s rsp;
   sfio_link_req_s lq;
   sfio_link_rsp_s ls;
   logic [7:0]     fm = 8'h00, fb = 8'h00, dl = 8'h03, m, f, c;
   logic [31:0]    seed = 32'h6a05ed3a, v, u, cyc = 0;
   logic [31:0]    wd [8][3];
   logic [7:0]     ef [8] = '{default: 8'h00};
   logic [15:0]    a;
   int             bad_count = 0, num_checks = 0, s;
   // =====================================================================
   // clock and cycle count
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   sfio_host_port i_sfio_host_port (.clk(clk), .sys_rst(sys_rst),
      .axiReq(req), .axiRsp(rsp), .linkReq(lq), .linkRsp(ls));
   sfio_link_model i_sfio_link_model (.clk(clk), .sys_rst(sys_rst),
      .linkReq(lq), .failMask(fm), .fltBits(fb), .delay(dl),
      .linkRsp(ls));
   // =====================================================================
   // helpers
   task automatic wrap_up();
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s exp %h got %h", n, e, g);
         bad_count++;
      end
   endtask
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [11:0] ra(int ch, int k); // k 0 is status
      return 12'(12'h100 + ch * 16 + k * 4);
   endfunction
   function automatic logic [31:0] ept(logic [7:0] op, logic [15:0] p);
      logic [31:0] d;
      d = {p, p ^ 16'h5a5a};
      return op == 8'h44 ? d & 32'hff : op == 8'h45 ? d & 32'hffff : d;
   endfunction
   // bus tasks end one edge late so no strobe is set twice in a step
   task automatic wr(logic [11:0] ad, logic [31:0] d, logic [1:0] e = 0);
      int n;
      n = 0;
      req.awaddr <= ad;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         n++;
      end while (!rsp.bvalid && n < 99);
      cmp("bresp", {30'h0, e}, {30'h0, rsp.bvalid ? rsp.bresp : 2'bxx});
      req.bready <= 1'b0;
      @(posedge clk);
      if (n >= 99) wrap_up();
   endtask
   task automatic rd(logic [11:0] ad, logic [1:0] e = 0);
      int n;
      n = 0;
      req.araddr <= ad;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
         n++;
      end while (!rsp.rvalid && n < 99);
      v = rsp.rdata;
      cmp("rresp", {30'h0, e}, {30'h0, rsp.rvalid ? rsp.rresp : 2'bxx});
      req.rready <= 1'b0;
      @(posedge clk);
      if (n >= 99) wrap_up();
   endtask
   task automatic chk(string n, logic [11:0] ad, logic [31:0] e);
      rd(ad);
      cmp(n, e, v);
   endtask
   // command, then poll until clear within lim cycles
   task automatic cmdw(logic [31:0] d, int lim);
      logic [31:0] t;
      t = cyc;
      wr(12'h000, d);
      do rd(12'h000); while (v !== 0 && cyc - t < 30000);
      cmp("cmd clear", 1, 32'(v === 0 && cyc - t <= lim));
      if (v !== 0) wrap_up();
   endtask
   // =====================================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("cmd", 12'h000, 0);
      chk("data", 12'h004, 0);
      rd(12'h0f0, 2'b10);
      wr(12'h0f0, rnd(), 2'b10);
      chk("hw mode", 12'h008, 32'h000000b0);
      chk("sw mode", 12'h00c, 32'h000100b0);
      {m, f} = 16'(rnd());
      fm <= f;
      cmdw({24'h000009, m}, 30000);
      chk("start fail", 12'h004, 32'(m & f));
      for (int i = 0; i < 8; i++)
         if (m[i] & ~f[i]) chk("unit", ra(i, 1), 32'h1000 | i);
      for (int r = 0; r < 3; r++) begin
         u = rnd();
         c = u[7:0] & ~f;
         fm <= u[15:8];
         fb <= u[23:16];
         for (int i = 0; i < 24; i++) begin
            wd[i / 3][i % 3] = rnd();
            wr(ra(i / 3, i % 3 + 1), wd[i / 3][i % 3]);
         end
         cmdw({24'h000010, c}, 4010);
         chk("cycle fail", 12'h004, 32'(c & (~m | u[15:8])));
         for (int i = 0; i < 24; i++) begin
            s = i / 3;
            if (i % 3 == 0 && c[s] & m[s]) ef[s] = ef[s] | u[23:16];
            if (c[s] & m[s] & ~u[8 + s]) begin
               chk("in word", ra(s, i % 3 + 1),
                   ~wd[s][i % 3] ^ s);
               chk("status", ra(s, 0),
                   {5'h0, 3'(s), 16'h0300, ef[s]});
            end else if (!(c[s] & m[s]))
               chk("kept", ra(s, i % 3 + 1), wd[s][i % 3]);
         end
      end
      fb <= 8'h00;
      fm <= 8'h00;
      cmdw(32'h0800, 20);
      for (int i = 0; i < 8; i++) begin
         rd(ra(i, 0));
         cmp("flt clear", 0, {24'h0, v[7:0]});
      end
      dl <= 8'd200;
      cmdw(32'h09ff, 30000);
      wr(12'h000, 32'h10ff);
      wr(12'h000, 32'h09ff);
      wr(12'h000, 32'h89ff);
      chk("busy cmd", 12'h000, 32'h10ff);
      cmdw(32'h0800, 20);
      cmdw(32'h1001, 4010);
      chk("idle", 12'h004, 1);
      dl <= 8'd2;
      s = int'(rnd() % 8);
      cmdw({24'h00000f, 8'h01 << s}, 30000);
      chk("setup fail", 12'h004, 0);
      for (int k = 0; k < 4; k++) begin
         a = 16'(rnd());
         wr(ra(s, 0), {8'h44 + 8'(k), 8'h00, a});
         cmdw({24'h000010, 8'h01 << s}, 4010);
         chk("pt data", 12'h004, 0);
         chk("pt word0", ra(s, 1), ept(8'h44 + 8'(k), a));
      end
      chk("pt word1", ra(s, 2), ~ept(8'h47, a));
      // pass-through word write: data right-justified, then command word
      wr(ra(s, 1), {16'h0000, a});
      wr(ra(s, 0), {16'h6500, a});
      cmdw({24'h000010, 8'h01 << s}, 4010);
      chk("pt wr data", 12'h004, 0);
      wrap_up();
   end
endmodule
